// [swsp_port.sv]
// Serial control port and side-band pins of a four-channel high side switch.
`timescale 1ns/1ns
`default_nettype none
`include "swsp_regs.svh"

module swsp_port
	import swsp_pkg::*;
#(
	parameter int FRAME_BITS = `SWSP_FRAME_BITS,
	parameter int ADDR_BITS = `SWSP_ADDR_BITS
) (
	// Clock and block reset.
	input wire logic clock,
	input wire logic rst,
	// Serial pins: select, clock and data in from the master, data out to it.
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_si,
	output logic spi_so_o,
	output logic spi_so_oe_n,
	// Side-band pins.
	input wire logic device_reset_n,
	input wire logic wake,
	input wire logic direct_input_0,
	input wire logic direct_input_1,
	input wire logic direct_input_2,
	input wire logic direct_input_3,
	// Output channel controls.
	output logic high_side_output_0,
	output logic high_side_output_1,
	output logic high_side_output_2,
	output logic high_side_output_3,
	// Open-drain fault flag.
	output logic fault_flag_n_o,
	output logic fault_flag_n_oe_n,
	// Sense output control.
	output logic analog_sense_output_enable,
	output logic analog_sense_output_temp,
	output logic [1:0] analog_sense_output_channel,
	// Device logic on the same clock.
	input wire logic [15:0] status_word,
	input wire logic fault_detect,
	input wire logic [3:0] pwm_gate,
	output logic reg_write,
	output logic [4:0] reg_addr,
	output logic [15:0] reg_frame,
	output logic watchdog_start,
	output logic pwm_clock_tick,
	output logic device_awake
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// The shifters, counter and field macros are sized for this exact frame.
	if (FRAME_BITS != `SWSP_FRAME_BITS || ADDR_BITS != `SWSP_ADDR_BITS) begin : g_bad_params
		$error("swsp_port supports only 16-bit frames with 5-bit addresses.");
	end

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Order: cs_n, sclk, si, reset_n, wake, din3..din0.
	localparam int NPINS = 9;
	logic [NPINS-1:0] pins;
	logic [NPINS-1:0] meta_q, meta_d;
	logic [NPINS-1:0] sync_q, sync_d;
	logic [NPINS-1:0] prev_q, prev_d;

	assign pins = {spi_cs_n, spi_sclk, spi_si, device_reset_n, wake,
		direct_input_3, direct_input_2, direct_input_1, direct_input_0};

	// Two stages per pin; prev_q only feeds edge detection of the settled value.
	always_comb begin
		meta_d = pins;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			// Idle pin levels, so that no false edge follows reset.
			meta_q <= `SWSP_PIN_RESET;
			sync_q <= `SWSP_PIN_RESET;
			prev_q <= `SWSP_PIN_RESET;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	// Settled pin levels and edges.
	logic cs_n_s, sclk_s, si_s, rstpin_s, wake_s;
	logic [3:0] din_s;
	logic cs_fall, cs_rise, sclk_fall, sclk_rise, rstpin_rise, din0_rise;

	assign cs_n_s = sync_q[8];
	assign sclk_s = sync_q[7];
	assign si_s = sync_q[6];
	assign rstpin_s = sync_q[5];
	assign wake_s = sync_q[4];
	assign din_s = sync_q[3:0];
	assign cs_fall = prev_q[8] & ~cs_n_s;
	assign cs_rise = ~prev_q[8] & cs_n_s;
	// SCLK and SI pass equal delays, so SI stays aligned with the sampled clock edge.
	assign sclk_fall = prev_q[7] & ~sclk_s;
	assign sclk_rise = ~prev_q[7] & sclk_s;
	assign rstpin_rise = ~prev_q[5] & rstpin_s;
	assign din0_rise = ~prev_q[0] & din_s[0];

	// ----------------------------------------
	// Frame engine
	// ----------------------------------------
	swsp_state_e state_q, state_d;
	logic [15:0] in_sr_q, in_sr_d;
	logic [15:0] out_sr_q, out_sr_d;
	logic [4:0] cnt_q, cnt_d;
	logic so_oe_n_q, so_oe_n_d;
	logic wr_q, wr_d;
	swsp_addr_t wr_addr_q, wr_addr_d;
	logic [15:0] wr_frame_q, wr_frame_d;

	// Edge counter saturates just past a full frame, so long frames stay rejected.
	function automatic logic [4:0] swsp_count_up(input logic [4:0] c);
		swsp_count_up = (c == `SWSP_CNT_OVER) ? c : c + 5'h01;
	endfunction : swsp_count_up

	always_comb begin
		state_d = state_q;
		in_sr_d = in_sr_q;
		out_sr_d = out_sr_q;
		cnt_d = cnt_q;
		so_oe_n_d = so_oe_n_q;
		wr_d = 1'b0;
		wr_addr_d = wr_addr_q;
		wr_frame_d = wr_frame_q;
		unique case (state_q)
			SWSP_IDLE: begin
				// Clock and data are not looked at while deselected.
				so_oe_n_d = 1'b1;
				if (cs_fall) begin
					out_sr_d = status_word;
					cnt_d = `SWSP_CNT_ZERO;
					so_oe_n_d = 1'b0;
					state_d = SWSP_FRAME;
				end
			end
			SWSP_FRAME: begin
				if (cs_rise) begin
					so_oe_n_d = 1'b1;
					state_d = SWSP_IDLE;
					// Partial or overlong frames leave all settings as they were.
					if (cnt_q == `SWSP_CNT_FULL) begin
						wr_d = 1'b1;
						wr_frame_d = in_sr_q;
						wr_addr_d = in_sr_q[`SWSP_ADDR_MSB:`SWSP_ADDR_LSB];
					end
				end else begin
					if (sclk_fall) begin
						in_sr_d = {in_sr_q[14:0], si_s};
						cnt_d = swsp_count_up(cnt_q);
					end
					if (sclk_rise) begin
						out_sr_d = {out_sr_q[14:0], 1'b0};
					end
				end
			end
		endcase
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			state_q <= SWSP_IDLE;
			in_sr_q <= 16'h0000;
			out_sr_q <= 16'h0000;
			cnt_q <= `SWSP_CNT_ZERO;
			so_oe_n_q <= 1'b1;
			wr_q <= 1'b0;
			wr_addr_q <= 5'h00;
			wr_frame_q <= 16'h0000;
		end else begin
			state_q <= state_d;
			in_sr_q <= in_sr_d;
			out_sr_q <= out_sr_d;
			cnt_q <= cnt_d;
			so_oe_n_q <= so_oe_n_d;
			wr_q <= wr_d;
			wr_addr_q <= wr_addr_d;
			wr_frame_q <= wr_frame_d;
		end
	end

	// ----------------------------------------
	// Wake, watchdog start and local settings
	// ----------------------------------------
	logic awake_q, awake_d;
	logic wdog_q, wdog_d;
	logic [4:0] outctl_q, outctl_d;
	logic [3:0] sense_q, sense_d;
	logic fault_q, fault_d;
	logic tick_q, tick_d;
	logic sen_en_q, sen_en_d;

	// Settings stay cleared while the reset pin is low or the part sleeps; so does the fault latch, except while fault_detect is high.
	always_comb begin
		awake_d = rstpin_s | wake_s | (|din_s);
		wdog_d = rstpin_rise;
		outctl_d = outctl_q;
		sense_d = sense_q;
		if (wr_q && wr_addr_q == `SWSP_ADDR_OUTCTL) begin
			outctl_d = wr_frame_q[4:0];
		end
		if (wr_q && wr_addr_q == `SWSP_ADDR_SENSE) begin
			sense_d = wr_frame_q[3:0];
		end
		fault_d = fault_q;
		if (!rstpin_s || !awake_q) begin
			outctl_d = `SWSP_OUTCTL_RESET;
			sense_d = `SWSP_SENSE_RESET;
			fault_d = 1'b0;
		end
		// A fault seen in a clearing cycle wins for one cycle; the next clearing cycle drops it again.
		if (fault_detect) begin
			fault_d = 1'b1;
		end
		// Registered on its own so the sense enable pin comes straight from a flop.
		sen_en_d = ~sense_d[`SWSP_SENSE_HIZ];
		tick_d = outctl_q[`SWSP_OUTCTL_PWM_EXT] & din0_rise;
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			awake_q <= 1'b0;
			wdog_q <= 1'b0;
			outctl_q <= `SWSP_OUTCTL_RESET;
			sense_q <= `SWSP_SENSE_RESET;
			fault_q <= 1'b0;
			tick_q <= 1'b0;
			sen_en_q <= 1'b0; // The sense reset value has the high-impedance bit set.
		end else begin
			awake_q <= awake_d;
			wdog_q <= wdog_d;
			outctl_q <= outctl_d;
			sense_q <= sense_d;
			fault_q <= fault_d;
			tick_q <= tick_d;
			sen_en_q <= sen_en_d;
		end
	end

	// ----------------------------------------
	// Output channels and fault flag
	// ----------------------------------------
	logic [3:0] hs_q, hs_d;
	logic [3:0] direct_en;
	logic flag_oe_n_q, flag_oe_n_d;

	// In external-clock PWM mode input 0 is a time base, not a switch command.
	assign direct_en = {3'b111, ~outctl_q[`SWSP_OUTCTL_PWM_EXT]};

	always_comb begin
		hs_d = {4{awake_q}} & ((din_s & direct_en) | outctl_q[3:0] | pwm_gate);
		flag_oe_n_d = ~(fault_q | fault_detect);
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			hs_q <= 4'h0;
			flag_oe_n_q <= 1'b1;
		end else begin
			hs_q <= hs_d;
			flag_oe_n_q <= flag_oe_n_d;
		end
	end

	// ----------------------------------------
	// Port drive
	// ----------------------------------------
	assign spi_so_o = out_sr_q[15];
	assign spi_so_oe_n = so_oe_n_q;
	assign high_side_output_0 = hs_q[0];
	assign high_side_output_1 = hs_q[1];
	assign high_side_output_2 = hs_q[2];
	assign high_side_output_3 = hs_q[3];
	// Open drain: the data bit is always low, only the enable moves.
	assign fault_flag_n_o = 1'b0;
	assign fault_flag_n_oe_n = flag_oe_n_q;
	assign analog_sense_output_enable = sen_en_q;
	assign analog_sense_output_temp = sense_q[`SWSP_SENSE_TEMP];
	assign analog_sense_output_channel = sense_q[`SWSP_SENSE_CH_MSB:0];
	assign reg_write = wr_q;
	assign reg_addr = wr_addr_q;
	assign reg_frame = wr_frame_q;
	assign watchdog_start = wdog_q;
	assign pwm_clock_tick = tick_q;
	assign device_awake = awake_q;

endmodule : swsp_port
`default_nettype wire

// [swsp_regs.svh]
// Constants of the switch serial control port: frame layout, addresses and reset values.
`ifndef SWSP_REGS_SVH
`define SWSP_REGS_SVH

// ----------------------------------------
// Frame layout
// ----------------------------------------
`define SWSP_FRAME_BITS 16
`define SWSP_ADDR_BITS 5
`define SWSP_ADDR_MSB 14
`define SWSP_ADDR_LSB 10
`define SWSP_CNT_ZERO 5'h00
`define SWSP_CNT_FULL 5'h10
`define SWSP_CNT_OVER 5'h11

// ----------------------------------------
// Pin synchroniser idle levels
// ----------------------------------------
// Order cs_n, sclk, si, reset_n, wake, din3..din0: only chip select and reset pin idle high.
`define SWSP_PIN_RESET 9'h120

// ----------------------------------------
// Locally held settings
// ----------------------------------------
`define SWSP_ADDR_OUTCTL 5'h01
`define SWSP_ADDR_SENSE 5'h02
`define SWSP_OUTCTL_PWM_EXT 4
`define SWSP_SENSE_HIZ 3
`define SWSP_SENSE_TEMP 2
`define SWSP_SENSE_CH_MSB 1
`define SWSP_OUTCTL_RESET 5'h00
`define SWSP_SENSE_RESET 4'h8

`endif

// [swsp_pkg.sv]
// Types shared by the switch serial control port.
`default_nettype none
package swsp_pkg;
	typedef enum logic {SWSP_IDLE, SWSP_FRAME} swsp_state_e;
	typedef logic [4:0] swsp_addr_t;
endpackage : swsp_pkg
`default_nettype wire

// [swsp_asserts.sv]
// Timing checker of the switch serial port.
`timescale 1ns/1ns
`default_nettype none
module swsp_asserts (
	// Clock and reset.
	input wire logic clock,
	input wire logic rst,
	// Serial port.
	input wire logic spi_cs_n,
	input wire logic spi_so_oe_n,
	input wire logic reg_write,
	input wire logic [4:0] reg_addr,
	input wire logic [15:0] reg_frame,
	// Side-band.
	input wire logic device_reset_n,
	input wire logic wake,
	input wire logic fault_detect,
	input wire logic fault_flag_n_o,
	input wire logic fault_flag_n_oe_n,
	input wire logic watchdog_start,
	input wire logic device_awake
);
	// ----
	// Properties
	// ----
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	// A deselect first seen three cycles back; commits trail it by the sync delay.
	sequence cs_rose_3;
		$past(spi_cs_n, 3) && !$past(spi_cs_n, 4);
	endsequence
	AST_SO_HIZ: assert property (spi_cs_n [*5] |=> spi_so_oe_n)
		else $error("SO driven while deselected.");
	AST_SO_EN: assert property ($fell(spi_cs_n) |-> ##4 !spi_so_oe_n)
		else $error("SO not driven after select.");
	AST_COMMIT: assert property (reg_write |-> cs_rose_3)
		else $error("Commit not tied to deselect.");
	AST_ADDR: assert property (reg_write |-> reg_addr == reg_frame[14:10])
		else $error("Address field wrong.");
	AST_WDOG: assert property ($rose(device_reset_n) |-> ##3 watchdog_start)
		else $error("Watchdog start missing.");
	AST_FAULT: assert property (fault_detect |=> !fault_flag_n_oe_n)
		else $error("Fault flag not pulled.");
	AST_FLAG_LOW: assert property (fault_flag_n_o == 1'b0)
		else $error("Fault flag data not low.");
	AST_WAKE: assert property (wake [*5] |-> device_awake)
		else $error("Wake pin ignored.");
endmodule : swsp_asserts
bind swsp_port swsp_asserts u_chk (.clock, .rst, .spi_cs_n, .spi_so_oe_n, .reg_write, .reg_addr,
	.reg_frame, .device_reset_n, .wake, .fault_detect, .fault_flag_n_o, .fault_flag_n_oe_n,
	.watchdog_start, .device_awake);
`default_nettype wire

// [swsp_master.sv]
// Serial master model that runs frames against the port.
`timescale 1ns/1ns
`default_nettype none
module swsp_master (
	// Bench clock.
	input wire logic clock,
	// Serial pins.
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_si,
	input wire logic spi_so_o
);
	// Idle: deselected with the clock parked low.
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		spi_si = 1'b0;
	end
	// Ten cycles per half period give the 80 ns serial clock.
	task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
		int i;
		rx = 16'h0000;
		spi_cs_n <= 1'b0;
		repeat (20) @(posedge clock);
		for (i = 0; i < n; i++) begin
			rx = {rx[14:0], spi_so_o};
			spi_si <= w[15 - (i % 16)];
			spi_sclk <= 1'b1;
			repeat (10) @(posedge clock);
			spi_sclk <= 1'b0;
			repeat (10) @(posedge clock);
		end
		spi_cs_n <= 1'b1;
		spi_si <= ~spi_si;
		repeat (20) @(posedge clock);
	endtask : xfer
endmodule : swsp_master
`default_nettype wire

// [tb_switch_spi_slave_port.sv]
// Self-checking bench of the switch serial control port.
`timescale 1ns/1ns
`default_nettype none
`include "swsp_regs.svh"
module tb_switch_spi_slave_port;
	logic clock = 1'b0, rst = 1'b1, spi_cs_n, spi_sclk, spi_si, spi_so_o, spi_so_oe_n;
	logic device_reset_n, wake, fault_detect, flag_o, flag_oe_n, sen_en, sen_temp;
	logic reg_write, watchdog_start, pwm_clock_tick, device_awake;
	logic [1:0] sen_ch;
	logic [3:0] din, hs, pwm_gate;
	logic [4:0] reg_addr;
	logic [15:0] status_word, reg_frame;
	logic [15:0] expq[$];
	int num_errors = 0, total_checks = 0, seed = 32'h84fd, ticks = 0, wdogs = 0;
	logic so_pin;
	always #2 clock = ~clock;
	// A released serial output shows the inverse of its data, so a read outside the drive window fails.
	assign so_pin = spi_so_oe_n ? ~spi_so_o : spi_so_o;
	swsp_master u_mst (.clock, .spi_cs_n, .spi_sclk, .spi_si, .spi_so_o(so_pin));
	swsp_port dut (.clock, .rst, .spi_cs_n, .spi_sclk, .spi_si, .spi_so_o, .spi_so_oe_n,
		.device_reset_n, .wake, .direct_input_0(din[0]), .direct_input_1(din[1]),
		.direct_input_2(din[2]), .direct_input_3(din[3]), .high_side_output_0(hs[0]),
		.high_side_output_1(hs[1]), .high_side_output_2(hs[2]), .high_side_output_3(hs[3]),
		.fault_flag_n_o(flag_o), .fault_flag_n_oe_n(flag_oe_n), .analog_sense_output_enable(sen_en),
		.analog_sense_output_temp(sen_temp), .analog_sense_output_channel(sen_ch), .status_word,
		.fault_detect, .pwm_gate, .reg_write, .reg_addr, .reg_frame, .watchdog_start,
		.pwm_clock_tick, .device_awake);
	// ----
	// Checking
	// ----
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	task automatic end_of_test;
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test
	// Each commit must match the oldest frame the model expects; a stray one is a mismatch.
	always @(posedge clock) begin
		if (reg_write === 1'b1 && expq.size() == 0) check(1'b1, 1'b0);
		if (reg_write === 1'b1 && expq.size() > 0) begin
			check(reg_frame, expq[0]);
			check(reg_addr, expq[0][14:10]);
			void'(expq.pop_front());
		end
		if (pwm_clock_tick === 1'b1) ticks++;
		if (watchdog_start === 1'b1) wdogs++;
	end
	// Only whole frames enter the model; the status read must be the loaded word.
	task automatic frame(input logic [15:0] w, input int n);
		logic [15:0] rx;
		if (n == 16) expq.push_back(w);
		u_mst.xfer(w, n, rx);
		if (n == 16) check(rx, status_word);
		check(16'(expq.size()), 16'h0000);
	endtask : frame
	// Hang guard, well above the length of the sequence.
	initial begin
		repeat (20000) @(posedge clock);
		num_errors++;
		end_of_test();
	end
	// ----
	// Main sequence
	// ----
	initial begin
		int i;
		device_reset_n = 1'b1;
		wake = 1'b0;
		din = 4'h0;
		fault_detect = 1'b0;
		pwm_gate = 4'h0;
		status_word = 16'h0000;
		repeat (6) @(posedge clock);
		check(spi_so_oe_n, 1'b1);
		check(sen_en, 1'b0);
		rst <= 1'b0;
		repeat (4) @(posedge clock);
		$display("test reset done");
		// Random frames to high addresses, away from the two local settings.
		for (i = 0; i < 6; i++) begin
			status_word <= 16'($random(seed));
			frame(16'($random(seed)) | 16'h4000, 16);
		end
		frame(16'h4555, 15);
		frame(16'h4555, 17);
		$display("test frames done");
		frame({1'b0, `SWSP_ADDR_OUTCTL, 10'h005}, 16);
		check(hs, 4'h5);
		frame({1'b0, `SWSP_ADDR_SENSE, 10'h006}, 16);
		check({sen_en, sen_temp, sen_ch}, 4'he);
		frame({1'b0, `SWSP_ADDR_SENSE, 10'h008}, 16);
		check(sen_en, 1'b0);
		frame(16'h0400, 16);
		for (i = 0; i < 3; i++) begin
			din <= 4'($random(seed));
			pwm_gate <= 4'h0;
			repeat (8) @(posedge clock);
			check(hs, din);
		end
		din <= 4'h0;
		$display("test settings done");
		frame(16'h0410, 16);
		ticks = 0;
		for (i = 0; i < 5; i++) begin
			din[0] <= 1'b1;
			repeat (10) @(posedge clock);
			din[0] <= 1'b0;
			repeat (10) @(posedge clock);
		end
		check(16'(ticks), 16'h0005);
		frame(16'h0403, 16);
		fault_detect <= 1'b1;
		@(posedge clock);
		fault_detect <= 1'b0;
		repeat (3) @(posedge clock);
		check({flag_oe_n, flag_o}, 2'b00);
		device_reset_n <= 1'b0;
		repeat (2500) @(posedge clock);
		check({hs, flag_oe_n, device_awake}, 6'h02);
		wdogs = 0;
		device_reset_n <= 1'b1;
		repeat (8) @(posedge clock);
		check(16'(wdogs), 16'h0001);
		check(device_awake, 1'b1);
		device_reset_n <= 1'b0;
		repeat (6) @(posedge clock);
		wake <= 1'b1;
		repeat (6) @(posedge clock);
		check(device_awake, 1'b1);
		wake <= 1'b0;
		din <= 4'h4;
		repeat (6) @(posedge clock);
		check(device_awake, 1'b1);
		$display("test side band done");
		end_of_test();
	end
endmodule : tb_switch_spi_slave_port
`default_nettype wire
